/* File: rtl/dhrs_reset_seq.sv */
`timescale 1ns/1ps
// Overview of operation
// - host holds reset low 10 us; under 5 us ignored, over 9 us resets
// - brief glitches during a valid low neither cancel nor restart the reset
// - on release, stored settings reload into registers within 5 ms
// - display blanked during reset; awake start blanks up to 120 ms, then defaults
// - cancel period ends by 5 ms asleep, by 120 ms awake
module dhrs_reset_seq #(
    parameter int LOAD_CYC = dhrs_pkg::LOAD_CYC,
    parameter int BLANK_CYC = dhrs_pkg::BLANK_CYC,
    parameter int ACCEPT_CYC = dhrs_pkg::ACCEPT_CYC,
    parameter int GLITCH_CYC = dhrs_pkg::GLITCH_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hw_reset_line_n,
    input wire logic sleep_out,
    output logic display_blank,
    output logic regs_default,
    output logic cancel_busy,
    output dhrs_pkg::dhrs_load_s load_word,
    output logic [dhrs_pkg::DATA_W-1:0] common_voltage_setting
);
    logic reset_qualified;
    logic line_low;
    dhrs_pkg::dhrs_state_e state;
    dhrs_pkg::dhrs_state_e next_state;
    logic [dhrs_pkg::CNT_W-1:0] cnt;
    logic was_awake;
    logic [dhrs_pkg::NVM_AW-1:0] addr;
    logic [dhrs_pkg::DATA_W-1:0] stored_settings_memory [dhrs_pkg::NVM_WORDS];

    dhrs_pin_filter #(
        .ACCEPT_CYC(ACCEPT_CYC),
        .GLITCH_CYC(GLITCH_CYC)
    ) u_filter (
        .clk(clk),
        .sys_rst(sys_rst),
        .hw_reset_line_n(hw_reset_line_n),
        .reset_qualified(reset_qualified),
        .line_low(line_low)
    );

    // fixed contents stand in for the fused store; values are arbitrary
    genvar gi;
    generate
        for (gi = 0; gi < dhrs_pkg::NVM_WORDS; gi++) begin : g_nvm
            assign stored_settings_memory[gi] = 8'(8'h10 + gi);
        end
    endgenerate

    // release counts only once the glitch bridge drops qualification, so a short high in hold is ignored
    wire released = ~reset_qualified;
    wire load_last = addr == dhrs_pkg::NVM_AW'(dhrs_pkg::NVM_WORDS - 1);
    // release reaches the sequencer a sync and a glitch bridge late; blanking ends that much sooner
    localparam int BLANK_END = BLANK_CYC - GLITCH_CYC - 10;
    wire blank_over = cnt >= dhrs_pkg::CNT_W'(BLANK_END);
    // a sleeping display stays blank after the sequence until it is woken
    wire stay_blank = state == dhrs_pkg::DHRS_RUN && display_blank && !sleep_out;
    wire blank_next = next_state != dhrs_pkg::DHRS_RUN || stay_blank
        || (state == dhrs_pkg::DHRS_DONE && !was_awake);
    wire load_over = cnt >= dhrs_pkg::CNT_W'(LOAD_CYC - 1);

    // sequencing after a qualified low
    always_comb begin
        next_state = state;
        case (state)
            dhrs_pkg::DHRS_RUN: if (reset_qualified) next_state = dhrs_pkg::DHRS_HOLD;
            dhrs_pkg::DHRS_HOLD: if (released) next_state = dhrs_pkg::DHRS_LOAD;
            dhrs_pkg::DHRS_LOAD: begin
                if (load_last) begin
                    next_state = was_awake ? dhrs_pkg::DHRS_BLANK : dhrs_pkg::DHRS_DONE;
                end
            end
            dhrs_pkg::DHRS_BLANK: if (blank_over) next_state = dhrs_pkg::DHRS_DONE;
            dhrs_pkg::DHRS_DONE: next_state = dhrs_pkg::DHRS_RUN;
            default: next_state = dhrs_pkg::DHRS_RUN;
        endcase
    end

    // new qualified low during the cancel period restarts the sequence
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= dhrs_pkg::DHRS_RUN;
        end else if (reset_qualified && state != dhrs_pkg::DHRS_HOLD) begin
            state <= dhrs_pkg::DHRS_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // elapsed time since release, and awake flag latched when a reset starts from run
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt <= '0;
            was_awake <= 1'b0;
        end else begin
            cnt <= (state == dhrs_pkg::DHRS_HOLD || state == dhrs_pkg::DHRS_RUN) ? '0 : cnt + 1'b1;
            if (state == dhrs_pkg::DHRS_RUN && reset_qualified) begin
                was_awake <= sleep_out;
            end
        end
    end

    // one stored word per cycle, well inside the load limit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr <= '0;
            load_word <= '0;
            common_voltage_setting <= 8'h00;
        end else begin
            load_word.valid <= state == dhrs_pkg::DHRS_LOAD;
            load_word.addr <= addr;
            load_word.data <= stored_settings_memory[addr];
            addr <= state == dhrs_pkg::DHRS_LOAD ? addr + 1'b1 : '0;
            if (state == dhrs_pkg::DHRS_LOAD && addr == '0) begin
                common_voltage_setting <= stored_settings_memory[addr];
            end
        end
    end

    // blanking holds through reset and its tail; sleeping start stays blank
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            display_blank <= 1'b1;
            regs_default <= 1'b1;
            cancel_busy <= 1'b1;
        end else begin
            display_blank <= blank_next;
            regs_default <= state == dhrs_pkg::DHRS_DONE ? 1'b1 : (state == dhrs_pkg::DHRS_HOLD ? 1'b0 : regs_default);
            cancel_busy <= next_state != dhrs_pkg::DHRS_RUN;
        end
    end

    // checks
    logic [dhrs_pkg::CNT_W-1:0] since_rel;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            since_rel <= '0;
        end else begin
            since_rel <= (state == dhrs_pkg::DHRS_HOLD || state == dhrs_pkg::DHRS_RUN) ? '0 : since_rel + 1'b1;
        end
    end
    property p_load_in_time;
        @(posedge clk) disable iff (sys_rst) load_word.valid |-> since_rel <= dhrs_pkg::CNT_W'(LOAD_CYC);
    endproperty
    a_load_in_time: assert property (p_load_in_time) else $error("load past limit");
    property p_cancel_bound;
        @(posedge clk) disable iff (sys_rst) cancel_busy |-> since_rel <= dhrs_pkg::CNT_W'(BLANK_CYC + 2);
    endproperty
    a_cancel_bound: assert property (p_cancel_bound) else $error("cancel too long");
    property p_sleep_short;
        @(posedge clk) disable iff (sys_rst)
            (state == dhrs_pkg::DHRS_DONE && !was_awake) |-> since_rel <= dhrs_pkg::CNT_W'(LOAD_CYC);
    endproperty
    a_sleep_short: assert property (p_sleep_short) else $error("asleep cancel too long");
    property p_blank_hold;
        @(posedge clk) disable iff (sys_rst) state == dhrs_pkg::DHRS_HOLD |=> display_blank;
    endproperty
    a_blank_hold: assert property (p_blank_hold) else $error("not blank in reset");
    property p_qual_start;
        @(posedge clk) disable iff (sys_rst) $rose(reset_qualified) |=> state == dhrs_pkg::DHRS_HOLD;
    endproperty
    a_qual_start: assert property (p_qual_start) else $error("reset not begun");
    property p_no_start;
        @(posedge clk) disable iff (sys_rst)
            (state == dhrs_pkg::DHRS_RUN && !reset_qualified) |=> state != dhrs_pkg::DHRS_HOLD;
    endproperty
    a_no_start: assert property (p_no_start) else $error("unqualified reset");
    // first high cycle inside a qualified low must not leave hold
    property p_glitch_hold;
        @(posedge clk) disable iff (sys_rst)
            (state == dhrs_pkg::DHRS_HOLD && !line_low && $past(line_low)) |=> state == dhrs_pkg::DHRS_HOLD;
    endproperty
    a_glitch_hold: assert property (p_glitch_hold) else $error("glitch cancelled");
    property p_load_order;
        @(posedge clk) disable iff (sys_rst) $fell(state == dhrs_pkg::DHRS_HOLD) && !reset_qualified
            |=> state == dhrs_pkg::DHRS_LOAD;
    endproperty
    a_load_order: assert property (p_load_order) else $error("no reload after release");

    // words stream one per cycle in address order
    property p_load_step;
        @(posedge clk) disable iff (sys_rst) (state == dhrs_pkg::DHRS_LOAD && !load_last)
            |=> addr == dhrs_pkg::NVM_AW'($past(addr) + 1'b1);
    endproperty
    a_load_step: assert property (p_load_step) else $error("load address skipped");
    // the voltage word changes only while reloading
    property p_common_voltage_setting_hold;
        @(posedge clk) disable iff (sys_rst) state != dhrs_pkg::DHRS_LOAD |=> $stable(common_voltage_setting);
    endproperty
    a_common_voltage_setting_hold: assert property (p_common_voltage_setting_hold) else $error("voltage word moved");

    // a new qualified low at any later point starts over at hold
    property p_restart;
        @(posedge clk) disable iff (sys_rst) (reset_qualified && state != dhrs_pkg::DHRS_HOLD)
            |=> state == dhrs_pkg::DHRS_HOLD;
    endproperty
    a_restart: assert property (p_restart) else $error("restart missed");

    // defaults are lost in hold and back once the sequence ends
    property p_hold_clears;
        @(posedge clk) disable iff (sys_rst) state == dhrs_pkg::DHRS_HOLD |=> !regs_default;
    endproperty
    a_hold_clears: assert property (p_hold_clears) else $error("defaults kept in reset");
    property p_default_after;
        @(posedge clk) disable iff (sys_rst) state == dhrs_pkg::DHRS_DONE |=> regs_default;
    endproperty
    a_default_after: assert property (p_default_after) else $error("defaults not restored");

    // awake start shows the picture again, sleeping start keeps it dark
    property p_awake_shows;
        @(posedge clk) disable iff (sys_rst) (state == dhrs_pkg::DHRS_DONE && was_awake) |=> !display_blank;
    endproperty
    a_awake_shows: assert property (p_awake_shows) else $error("awake display left blank");
    property p_sleep_blank;
        @(posedge clk) disable iff (sys_rst)
            (state == dhrs_pkg::DHRS_RUN && display_blank && !sleep_out) |=> display_blank;
    endproperty
    a_sleep_blank: assert property (p_sleep_blank) else $error("sleeping display unblanked");

    // main scenarios
    c_awake: cover property (@(posedge clk) state == dhrs_pkg::DHRS_BLANK ##1 state == dhrs_pkg::DHRS_DONE);
    c_asleep: cover property (@(posedge clk) state == dhrs_pkg::DHRS_LOAD ##1 state == dhrs_pkg::DHRS_DONE);
    c_qual: cover property (@(posedge clk) $rose(reset_qualified));
    c_restart: cover property (@(posedge clk) state == dhrs_pkg::DHRS_BLANK ##1 state == dhrs_pkg::DHRS_HOLD);
    c_glitch: cover property (@(posedge clk) state == dhrs_pkg::DHRS_HOLD && $fell(line_low));
endmodule

/* File: shared/dhrs_pkg.sv */
package dhrs_pkg;
    // clock rate and the times the block works with
    localparam int CLK_HZ = 25000000;
    localparam int SPIKE_REJECT_NS = 5000;    // low pulses shorter than this are ignored
    localparam int RESET_ACCEPT_NS = 9000;    // low pulses longer than this always reset
    localparam int LOAD_LIMIT_US = 5000;      // settings reload finished within this
    localparam int BLANK_LIMIT_US = 120000;   // awake blanking / cancel limit
    localparam int GLITCH_NS = 1000;          // highs shorter than this inside a pulse are ignored
    // derived cycle counts: least times round up, longest round down
    localparam int SPIKE_REJECT_CYC = (SPIKE_REJECT_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int ACCEPT_CYC = 200;   // qualify between 5 us and 9 us
    localparam int GLITCH_CYC = (GLITCH_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int LOAD_CYC = LOAD_LIMIT_US * (CLK_HZ / 1000000);
    localparam int BLANK_CYC = BLANK_LIMIT_US * (CLK_HZ / 1000000);
    localparam int CNT_W = 22;
    localparam int NVM_WORDS = 8;
    localparam int NVM_AW = 3;
    localparam int DATA_W = 8;

    typedef enum logic [2:0] {
        DHRS_RUN     = 3'b000,
        DHRS_HOLD    = 3'b001,
        DHRS_LOAD    = 3'b010,
        DHRS_BLANK   = 3'b011,
        DHRS_DONE    = 3'b100
    } dhrs_state_e;

    // one stored word moving from non-volatile memory to a register
    typedef struct packed {
        logic valid;
        logic [NVM_AW-1:0] addr;
        logic [DATA_W-1:0] data;
    } dhrs_load_s;
endpackage

/* File: rtl/dhrs_pin_filter.sv */
`timescale 1ns/1ps
// qualifies the reset line: counts low time and bridges short high glitches
module dhrs_pin_filter #(
    parameter int ACCEPT_CYC = dhrs_pkg::ACCEPT_CYC,
    parameter int GLITCH_CYC = dhrs_pkg::GLITCH_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hw_reset_line_n,
    output logic reset_qualified,
    output logic line_low
);
    logic [2:0] sync;
    logic [15:0] low_cnt;
    logic [15:0] high_cnt;
    // three stages; a change counts once the last two agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync <= 3'h7;
            line_low <= 1'b0;
        end else begin
            sync <= {sync[1:0], hw_reset_line_n};
            if (sync[2] == sync[1]) begin
                line_low <= ~sync[2];
            end
        end
    end
    wire long_high = line_low == 1'b0 && high_cnt >= 16'(GLITCH_CYC);
    // low time counter; a short high does not restart it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_cnt <= 16'h0000;
            high_cnt <= 16'h0000;
            reset_qualified <= 1'b0;
        end else begin
            high_cnt <= line_low ? 16'h0000 : high_cnt + 16'h0001;
            if (long_high) begin
                low_cnt <= 16'h0000;
                reset_qualified <= 1'b0;
            end else if (line_low && low_cnt < 16'(ACCEPT_CYC)) begin
                low_cnt <= low_cnt + 16'h0001;
            end else if (line_low) begin
                reset_qualified <= 1'b1;
            end
        end
    end
endmodule

/* File: test/dhrs_host_model.sv */
`timescale 1ns/1ps
// host side of the reset pin; the pin idles high as it is pulled up
module dhrs_host_model (
    input wire logic clk,
    output logic hw_reset_line_n,
    output logic sleep_out
);
    initial begin
        hw_reset_line_n = 1'b1;
        sleep_out = 1'b0;
    end
    // low pulse of lo cycles, with a high glitch of gl cycles at its middle
    task automatic pulse(input int lo, input int gl);
        @(negedge clk);
        hw_reset_line_n = 1'b0;
        repeat (lo / 2) @(negedge clk);
        hw_reset_line_n = (gl == 0) ? 1'b0 : 1'b1;
        repeat (gl) @(negedge clk);
        hw_reset_line_n = 1'b0;
        repeat (lo - lo / 2) @(negedge clk);
        hw_reset_line_n = 1'b1;
    endtask
    // leave sleep only after the full lock-out, so no early command
    task automatic wake(input int wait_cyc);
        repeat (wait_cyc) @(negedge clk);
        sleep_out = 1'b1;
    endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
// bench for the reset sequencer, host model on the pin
module testbench;
    localparam int LOAD_N = 50;
    localparam int BLANK_N = 200;
    localparam int ACCEPT_N = 20;
    localparam int GLITCH_N = 3;
    logic clk;
    logic sys_rst;
    logic hw_reset_line_n;
    logic sleep_out;
    logic display_blank;
    logic regs_default;
    logic cancel_busy;
    dhrs_pkg::dhrs_load_s load_word;
    logic [dhrs_pkg::DATA_W-1:0] common_voltage_setting;
    int errors = 0;
    int tests_run = 0;
    int words = 0;
    int busy_seen = 0;
    int unblanked = 0;

    dhrs_host_model u_dhrs_host_model (.clk(clk), .hw_reset_line_n(hw_reset_line_n), .sleep_out(sleep_out));
    dhrs_reset_seq #(.LOAD_CYC(LOAD_N), .BLANK_CYC(BLANK_N), .ACCEPT_CYC(ACCEPT_N), .GLITCH_CYC(GLITCH_N))
    u_dhrs_reset_seq (.clk(clk), .sys_rst(sys_rst), .hw_reset_line_n(hw_reset_line_n), .sleep_out(sleep_out),
        .display_blank(display_blank), .regs_default(regs_default), .cancel_busy(cancel_busy),
        .load_word(load_word), .common_voltage_setting(common_voltage_setting));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    // stored words must stream in address order with known contents
    always @(posedge clk) begin
        if (load_word.valid === 1'b1) begin
            check({29'h0, load_word.addr}, 32'(words % dhrs_pkg::NVM_WORDS));
            check({24'h0, load_word.data}, 32'h10 + 32'(words % dhrs_pkg::NVM_WORDS));
            words++;
        end
        if (!sys_rst && cancel_busy === 1'b1) busy_seen++;
        if (!sys_rst && cancel_busy === 1'b1 && display_blank !== 1'b1) unblanked++;
    end

    // bounded wait for the cancel period to end, counted from release
    task automatic wait_idle(output int n);
        n = 0;
        while (cancel_busy !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_spike();
        busy_seen = 0;
        u_dhrs_host_model.pulse(ACCEPT_N - 3, 0);
        repeat (10) @(negedge clk);
        check(32'(busy_seen), 32'h0);
        $display("spike test done");
    endtask

    task automatic t_asleep();
        int n;
        words = 0;
        u_dhrs_host_model.pulse(ACCEPT_N + 10, 0);
        check({31'h0, cancel_busy}, 32'h1);
        wait_idle(n);
        check(32'(n <= LOAD_N), 32'h1);
        check(32'(words), 32'h8);
        check(32'(common_voltage_setting), 32'h10);
        check({30'h0, display_blank, regs_default}, 32'h3);
        repeat (5) @(negedge clk);
        check({31'h0, display_blank}, 32'h1);
        $display("asleep reset test done");
    endtask

    // glitch splits the low in halves each shorter than the threshold
    task automatic t_awake_glitch();
        int n;
        words = 0;
        unblanked = 0;
        repeat (2) @(negedge clk);
        check({31'h0, display_blank}, 32'h0);
        u_dhrs_host_model.pulse(ACCEPT_N + 10, GLITCH_N - 1);
        check({31'h0, cancel_busy}, 32'h1);
        wait_idle(n);
        check(32'(n <= BLANK_N + 4), 32'h1);
        check(32'(words), 32'h8);
        check(32'(unblanked), 32'h0);
        check({30'h0, display_blank, regs_default}, 32'h1);
        $display("awake glitch test done");
    endtask

    // second low during blanking restarts; its glitch comes after qualification
    task automatic t_restart();
        int n;
        words = 0;
        unblanked = 0;
        u_dhrs_host_model.pulse(ACCEPT_N + 10, 0);
        repeat (20) @(negedge clk);
        check({31'h0, cancel_busy}, 32'h1);
        u_dhrs_host_model.pulse(2 * ACCEPT_N + 20, GLITCH_N - 1);
        wait_idle(n);
        check(32'(n <= BLANK_N + 4), 32'h1);
        check(32'(words), 32'h10);
        check(32'(unblanked), 32'h0);
        $display("restart test done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        t_spike();
        t_asleep();
        u_dhrs_host_model.wake(BLANK_N);
        t_awake_glitch();
        t_restart();
        end_of_test();
    end

    // whole run needs well under 1500 cycles
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule
